// [logic/bpd_ctrl.sv]
// Purpose: Control logic for a three-phase back-EMF zero-crossing detector
//          and its reference regulator, reached over APB.
// Assumes: Comparator outputs are synchronous to pclk.
// Notes:   Analog parts sit outside; this block drives their selects.
//
// The register addresses and the APB register port were left to the implementer.
`timescale 1ns/1ps
module bpd_ctrl
    import bpd_pkg::*;
#(
    parameter int PHASES = 3
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  clk_en,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [7:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [PHASES-1:0]     phase_compare_in,
    input  wire logic                  reference_output_good,
    output logic      [1:0]            neutral_source,
    output logic      [DAC_CODE_W-1:0] neutral_dac_code,
    output logic      [PHASES-1:0]     phase_enable,
    output logic      [PHASES-1:0]     zero_cross_event,
    output logic                       reference_regulator_enable,
    output logic      [TRIM_W-1:0]     reference_trim_field
);

    // ****************************************************************
    // Elaboration check.
    // ****************************************************************
    if (PHASES != 3) begin : g_bad
        $error("bpd_ctrl serves exactly three phases.");
    end

    // ****************************************************************
    // Register storage.
    // ****************************************************************
    logic [2:0]            neutral_sel;
    logic [PHASES-1:0]     phase_sel;
    logic [DAC_CODE_W-1:0] dac_code;
    logic [PHASES-1:0]     win_en;
    logic [PHASES-1:0]     filt_mode;
    logic [FILT_CNT_W-1:0] filt_cnt [PHASES];
    logic                  reference_regulator_disable;
    logic                  write_protect_unlock;
    logic                  reference_ready_flag;
    logic                  clamp_enable_bit;
    logic                  clamp_wait_done;
    logic [11:0]           clamp_cnt;
    logic [11:0]           settle_cnt;
    logic [FILT_CNT_W-1:0] stable_cnt [PHASES];
    logic [PHASES-1:0]     filt_state;
    logic [PHASES-1:0]     cmp_prev;

    wire wr_en = clk_en && psel && penable && pwrite;
    wire rd_en = clk_en && psel && penable && !pwrite;

    // Returns the index of a per-phase config register, or 3 if none.
    function automatic logic [1:0] phase_index(input logic [7:0] addr);
        unique case (addr)
            PHASE_CFG0_OFF: phase_index = 2'd0;
            PHASE_CFG1_OFF: phase_index = 2'd1;
            PHASE_CFG2_OFF: phase_index = 2'd2;
            default:    phase_index = 2'd3;
        endcase
    endfunction

    // Tells whether an address maps to a register.
    function automatic logic mapped(input logic [7:0] addr);
        mapped = (addr == PHASE_CTRL_OFF) || (phase_index(addr) != 2'd3) ||
                 (addr == REF_CTRL_OFF) || (addr == REF_CFG_OFF) ||
                 (addr == STATUS_OFF) || (addr == CLAMP_CTRL_OFF);
    endfunction

    // ****************************************************************
    // Phase control register.
    // ****************************************************************

    // Neutral source bits, phase selects and DAC code.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neutral_sel <= 3'h0;
            phase_sel   <= '0;
            dac_code    <= '0;
        end else if (wr_en && paddr == PHASE_CTRL_OFF) begin
            neutral_sel <= pwdata[NEUTRAL_PIN_BIT:NEUTRAL_NET_BIT];
            phase_sel   <= pwdata[PHASE_SEL_LSB +: PHASES];
            dac_code    <= pwdata[DAC_CODE_LSB +: DAC_CODE_W];
        end
    end

    // Per-phase window enable, filter mode and sample count.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            win_en    <= '0;
            filt_mode <= '0;
            for (int i = 0; i < PHASES; i++) begin
                filt_cnt[i] <= '0;
            end
        end else if (wr_en && phase_index(paddr) != 2'd3) begin
            win_en[phase_index(paddr)]    <= pwdata[WIN_EN_BIT];
            filt_mode[phase_index(paddr)] <= pwdata[FILT_MODE_BIT];
            filt_cnt[phase_index(paddr)]  <= pwdata[FILT_CNT_LSB +: FILT_CNT_W];
        end
    end

    // Neutral source to the analog switch; the pin beats the DAC beats the network.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            neutral_source   <= SRC_NONE;
            neutral_dac_code <= '0;
            phase_enable     <= '0;
        end else if (clk_en) begin
            if (neutral_sel[NEUTRAL_PIN_BIT]) begin
                neutral_source <= SRC_PIN;
            end else if (neutral_sel[NEUTRAL_DAC_BIT]) begin
                neutral_source <= SRC_DAC;
            end else if (neutral_sel[NEUTRAL_NET_BIT]) begin
                neutral_source <= SRC_NET;
            end else begin
                neutral_source <= SRC_NONE;
            end
            neutral_dac_code <= dac_code;
            phase_enable     <= phase_sel;
        end
    end

    // ****************************************************************
    // Window and filter stages, one per phase.
    // ****************************************************************

    // A comparator level must hold for filt_cnt + 2 samples in filtered mode; a
    // change of the filtered level is a zero crossing. Window enable restricts
    // events in filtered mode only; in unfiltered mode every crossing is flagged.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            filt_state       <= '0;
            cmp_prev         <= '0;
            zero_cross_event <= '0;
            for (int i = 0; i < PHASES; i++) begin
                stable_cnt[i] <= '0;
            end
        end else if (clk_en) begin
            for (int i = 0; i < PHASES; i++) begin
                cmp_prev[i]         <= phase_compare_in[i];
                zero_cross_event[i] <= 1'b0;
                if (!phase_sel[i]) begin
                    stable_cnt[i] <= '0;
                    filt_state[i] <= phase_compare_in[i];
                end else if (phase_compare_in[i] != cmp_prev[i]) begin
                    stable_cnt[i] <= '0;
                end else if (!filt_mode[i] || stable_cnt[i] >= filt_cnt[i]) begin
                    if (phase_compare_in[i] != filt_state[i]) begin
                        filt_state[i]       <= phase_compare_in[i];
                        zero_cross_event[i] <= win_en[i] ||
                                               !filt_mode[i];
                    end
                end else begin
                    stable_cnt[i] <= stable_cnt[i] + 1'b1;
                end
            end
        end
    end

    // ****************************************************************
    // Reference regulator.
    // ****************************************************************

    // Disable bit starts at 1; unlock bit gates trim writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_regulator_disable <= 1'b1;
            write_protect_unlock        <= 1'b0;
            clamp_enable_bit            <= 1'b0;
        end else if (wr_en && paddr == REF_CTRL_OFF) begin
            reference_regulator_disable <= pwdata[REF_DISABLE_BIT];
            write_protect_unlock        <= pwdata[REF_UNLOCK_BIT];
        end else if (wr_en && paddr == CLAMP_CTRL_OFF) begin
            clamp_enable_bit            <= pwdata[0];
        end
    end

    // Trim loads its factory value at reset; writes land only when unlocked.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reference_trim_field <= TRIM_DEFAULT;
        end else if (wr_en && paddr == REF_CFG_OFF && write_protect_unlock) begin
            reference_trim_field <= (pwdata[TRIM_W-1:0] > TRIM_MAX) ?
                                    TRIM_MAX : pwdata[TRIM_W-1:0];
        end
    end

    // Ready rises after the settle count once enabled and the output is good.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt                 <= '0;
            reference_ready_flag       <= 1'b0;
            reference_regulator_enable <= 1'b0;
        end else if (clk_en) begin
            reference_regulator_enable <= !reference_regulator_disable;
            if (reference_regulator_disable || !reference_output_good) begin
                settle_cnt           <= '0;
                reference_ready_flag <= 1'b0;
            end else if (settle_cnt == 12'(REF_SETTLE_CYC - 1)) begin
                reference_ready_flag <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + 12'h001;
            end
        end
    end

    // Clamp wait timer tells software when pre-drivers may be turned on.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clamp_cnt       <= '0;
            clamp_wait_done <= 1'b0;
        end else if (clk_en) begin
            if (!clamp_enable_bit) begin
                clamp_cnt       <= '0;
                clamp_wait_done <= 1'b0;
            end else if (clamp_cnt == 12'(CLAMP_WAIT_CYC - 1)) begin
                clamp_wait_done <= 1'b1;
            end else begin
                clamp_cnt <= clamp_cnt + 12'h001;
            end
        end
    end

    // ****************************************************************
    // APB read path and response.
    // ****************************************************************

    // Zero-wait answers; unmapped addresses read zero and raise pslverr.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else if (clk_en) begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped(paddr);
            prdata  <= 32'h0000_0000;
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    PHASE_CTRL_OFF: prdata <= 32'(neutral_sel) |
                        (32'(phase_sel) << PHASE_SEL_LSB) |
                        (32'(dac_code) << DAC_CODE_LSB);
                    PHASE_CFG0_OFF, PHASE_CFG1_OFF, PHASE_CFG2_OFF: prdata <=
                        32'(win_en[phase_index(paddr)]) |
                        (32'(filt_mode[phase_index(paddr)]) << FILT_MODE_BIT) |
                        (32'(filt_cnt[phase_index(paddr)]) << FILT_CNT_LSB);
                    REF_CTRL_OFF:   prdata <= 32'(reference_regulator_disable) |
                        (32'(write_protect_unlock) << REF_UNLOCK_BIT);
                    REF_CFG_OFF:    prdata <= 32'(reference_trim_field);
                    STATUS_OFF:     prdata <= 32'(reference_ready_flag) |
                        (32'(clamp_wait_done) << CLAMP_WAIT_BIT);
                    CLAMP_CTRL_OFF: prdata <= 32'(clamp_enable_bit);
                    default:        prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// [logic/bpd_pkg.sv]
// Purpose: Constants for the back-EMF phase detector control block.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes:   Offsets, field positions, reset values and timing counts live here.
//
// Contract
// - Neutral network enable selects resistor-network neutral.
// - DAC select routes 6-bit DAC to neutral.
// - Pin select takes neutral from reference pin.
// - Three independent phase select bits.
// - Each comparator feeds window and filter stage.
// - Zero crossing flagged when back-EMF equals neutral.
// - Three per-phase configuration register sets, 0..2.
// - Regulator disable resets to 1; 0 enables.
// - Ready flag sets once regulator output settles.
// - Reset loads factory trim, about 4.2 V.
// - Trim field spans 3.7 V to 4.9 V.
package bpd_pkg;

    // ****************************************************************
    // Register offsets (byte addresses).
    // ****************************************************************
    localparam logic [7:0] PHASE_CTRL_OFF = 8'h00;
    localparam logic [7:0] PHASE_CFG0_OFF = 8'h04;
    localparam logic [7:0] PHASE_CFG1_OFF = 8'h08;
    localparam logic [7:0] PHASE_CFG2_OFF = 8'h0C;
    localparam logic [7:0] REF_CTRL_OFF   = 8'h10;
    localparam logic [7:0] REF_CFG_OFF    = 8'h14;
    localparam logic [7:0] STATUS_OFF     = 8'h18;
    localparam logic [7:0] CLAMP_CTRL_OFF = 8'h1C;

    // ****************************************************************
    // Phase control register fields.
    // ****************************************************************
    localparam int NEUTRAL_NET_BIT = 0;
    localparam int NEUTRAL_DAC_BIT = 1;
    localparam int NEUTRAL_PIN_BIT = 2;
    localparam int PHASE_SEL_LSB   = 4;
    localparam int DAC_CODE_LSB    = 8;
    localparam int DAC_CODE_W      = 6;

    // ****************************************************************
    // Per-phase configuration fields.
    // ****************************************************************
    localparam int WIN_EN_BIT    = 0;
    localparam int FILT_MODE_BIT = 1;
    localparam int FILT_CNT_LSB  = 8;
    localparam int FILT_CNT_W    = 4;

    // ****************************************************************
    // Reference regulator fields, reset values and timing.
    // ****************************************************************
    localparam int REF_DISABLE_BIT = 0;
    localparam int REF_UNLOCK_BIT  = 1;
    localparam int TRIM_W          = 4;
    localparam logic [TRIM_W-1:0] TRIM_MAX = 4'hC;  // 3.7 V + 12 x 0.1 V = 4.9 V.
    localparam logic [TRIM_W-1:0] TRIM_DEFAULT = 4'h5;  // About 4.2 V.
    localparam int READY_BIT       = 0;
    localparam int CLAMP_WAIT_BIT  = 1;
    localparam int CLK_MHZ         = 20;
    localparam int REF_SETTLE_US   = 10;
    localparam int REF_SETTLE_CYC  = REF_SETTLE_US * CLK_MHZ;
    localparam int CLAMP_WAIT_US   = 100;
    localparam int CLAMP_WAIT_CYC  = CLAMP_WAIT_US * CLK_MHZ;

    // Neutral source encoding driven to the analog switch.
    localparam logic [1:0] SRC_NONE = 2'h0;
    localparam logic [1:0] SRC_NET  = 2'h1;
    localparam logic [1:0] SRC_DAC  = 2'h2;
    localparam logic [1:0] SRC_PIN  = 2'h3;

endpackage

// [testbench/bpd_ctrl_asserts.sv]
// Purpose: Port checker for bpd_ctrl.
// Assumes: clk_en is held high.
// Notes:   Bound to every bpd_ctrl instance.
`timescale 1ns/1ps
module bpd_ctrl_asserts
    import bpd_pkg::*;
#(
    parameter int PHASES = 3
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [PHASES-1:0] phase_compare_in,
    input wire logic [PHASES-1:0] phase_enable,
    input wire logic [PHASES-1:0] zero_cross_event,
    input wire logic              reference_regulator_enable,
    input wire logic [TRIM_W-1:0] reference_trim_field
);
    // *******
    // Bus mirrors and properties.
    // *******
    logic dis_q;
    logic unl_q;
    wire  wr_done = psel && penable && pwrite && pready;
    wire  ph_wr   = wr_done && paddr == PHASE_CTRL_OFF;
    wire  cfg_wr  = wr_done && paddr == REF_CFG_OFF;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Mirrors the regulator control bits when a write lands.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dis_q <= 1'b1;
            unl_q <= 1'b0;
        end else if (wr_done && paddr == REF_CTRL_OFF) begin
            dis_q <= pwdata[REF_DISABLE_BIT];
            unl_q <= pwdata[REF_UNLOCK_BIT];
        end
    end

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no pready after setup");
    a_err_unmapped: assert property (pready && paddr > CLAMP_CTRL_OFF |->
        pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
    a_reg_enable_lag: assert property (reference_regulator_enable == !$past(dis_q))
        else $error("regulator enable wrong");
    a_trim_in_range: assert property (reference_trim_field <= TRIM_MAX)
        else $error("trim above top code");
    a_trim_locked: assert property ($changed(reference_trim_field) |->
        $past(unl_q) && ($past(cfg_wr) || $past(cfg_wr, 2))) else $error("trim changed locked");
    a_phase_en_src: assert property ($changed(phase_enable) |->
        $past(ph_wr) || $past(ph_wr, 2)) else $error("phase enable moved without write");
    a_zc_selected: assert property (~|(zero_cross_event & ~phase_enable & ~$past(phase_enable)))
        else $error("event on deselected phase");
    a_zc_stable: assert property (|zero_cross_event |->
        ~|(($past(phase_compare_in) ^ $past(phase_compare_in, 2)) & zero_cross_event))
        else $error("event without stable input");
endmodule

bind bpd_ctrl bpd_ctrl_asserts #(.PHASES(PHASES)) u_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .phase_compare_in(phase_compare_in),
    .phase_enable(phase_enable), .zero_cross_event(zero_cross_event),
    .reference_regulator_enable(reference_regulator_enable),
    .reference_trim_field(reference_trim_field));

// [testbench/bpd_ctrl_bench.sv]
// Purpose: Self-checking bench for bpd_ctrl.
// Assumes: clk_en tied high; a model stands for the windings.
// Notes:   Reads and crossings are compared from queues.
`timescale 1ns/1ps
module bpd_ctrl_bench
    import bpd_pkg::*;
;
    // *******
    // Stimulus and checks.
    // *******
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, good, reg_en;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q, v;
    logic [1:0]  nsrc;
    logic [5:0]  dac;
    logic [2:0]  cmp, level, glitch, pen, zce, zc_q[$];
    logic [3:0]  trim;
    logic [32:0] m, exp_q[$], msk_q[$];
    int          fail_count = 0, checks_done = 0, n;

    // Toggles the clock every half period.
    always #25 pclk = ~pclk;

    bpd_ctrl DUT (.pclk(pclk), .presetn(presetn), .clk_en(1'b1), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .phase_compare_in(cmp), .reference_output_good(good),
        .neutral_source(nsrc), .neutral_dac_code(dac), .phase_enable(pen),
        .zero_cross_event(zce), .reference_regulator_enable(reg_en), .reference_trim_field(trim));
    bpd_motor_model u_motor (.pclk(pclk), .level(level), .glitch(glitch), .reg_en(reg_en),
        .cmp_out(cmp), .good(good));

    // Counts a comparison and reports a mismatch.
    task automatic check(input logic [32:0] got, input logic [32:0] want);
        checks_done++;
        if (got !== want) begin
            fail_count++;
            $display("mismatch at %0t got %h expected %h", $time, got, want);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Runs one bus transfer and keeps the read data in q.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // Notes the expected read word, then reads it.
    task automatic rd(input logic [7:0] a, input logic [32:0] want, input logic [32:0] mask);
        exp_q.push_back(want & mask);
        msk_q.push_back(mask);
        apb(1'b0, a, 32'h0);
    endtask

    // Takes the oldest note off a queue whenever a result shows.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            m = msk_q.pop_front();
            check({pslverr, prdata} & m, exp_q.pop_front());
        end
        if (zce !== 3'h0)
            check(33'(zce), zc_q.size() > 0 ? 33'(zc_q.pop_front()) : 33'h0);
    end

    // Runs the scenarios in order and ends with the verdict.
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, level, glitch} = '0;
        v = $urandom(32'hDFDC);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        check(33'({reg_en, nsrc, pen, trim}), 33'(TRIM_DEFAULT));
        rd(REF_CTRL_OFF, 33'h1, 33'h3);
        rd(8'h20, 33'h1_0000_0000, 33'h1_FFFF_FFFF);
        for (int i = 0; i < 8; i++) begin
            v = {18'h0, 6'($urandom), 1'b0, 3'(i), 1'b0, 3'(i)};
            apb(1'b1, PHASE_CTRL_OFF, v);
            rd(PHASE_CTRL_OFF, 33'(v), 33'h3F77);
            check(33'(nsrc), i[2] ? 33'(SRC_PIN) : i[1] ? 33'(SRC_DAC) : 33'(i[0]));
            check(33'({dac, pen}), 33'({v[13:8], v[6:4]}));
        end
        apb(1'b1, REF_CFG_OFF, 32'h9);
        rd(REF_CFG_OFF, 33'(TRIM_DEFAULT), 33'hF);
        apb(1'b1, REF_CTRL_OFF, 32'h3);
        for (int i = 0; i < 8; i++) begin
            v = (i == 0) ? 32'hF : 32'($urandom_range(15, 0));
            apb(1'b1, REF_CFG_OFF, v);
            rd(REF_CFG_OFF, (v[3:0] > TRIM_MAX) ? 33'(TRIM_MAX) : 33'(v[3:0]), 33'hF);
            check(33'(trim), (v[3:0] > TRIM_MAX) ? 33'(TRIM_MAX) : 33'(v[3:0]));
        end
        apb(1'b1, REF_CTRL_OFF, 32'h2);
        rd(STATUS_OFF, 33'h0, 33'h1);
        check(33'(reg_en), 33'h1);
        n = 0;
        do begin
            repeat (10) @(posedge pclk);
            apb(1'b0, STATUS_OFF, 32'h0);
            n++;
        end while (q[READY_BIT] !== 1'b1 && n < 60);
        check(33'(q[READY_BIT]), 33'h1);
        if (q[READY_BIT] !== 1'b1)
            report_and_stop();
        apb(1'b1, CLAMP_CTRL_OFF, 32'h1);
        rd(STATUS_OFF, 33'h0, 33'h2);
        repeat (CLAMP_WAIT_CYC - 10) @(posedge pclk);
        rd(STATUS_OFF, 33'h0, 33'h2);
        repeat (10) @(posedge pclk);
        rd(STATUS_OFF, 33'h2, 33'h2);
        for (int p = 0; p < 3; p++) begin
            v = {20'h0, 4'($urandom_range(15, 1)), 6'h0, 1'($urandom), 1'b1};
            apb(1'b1, PHASE_CFG0_OFF + 8'(4 * p), v);
            rd(PHASE_CFG0_OFF + 8'(4 * p), 33'(v), 33'hF03);
        end
        apb(1'b1, PHASE_CTRL_OFF, 32'h71);
        for (int p = 0; p < 6; p++) begin
            zc_q.push_back(3'(1 << (p % 3)));
            level[p % 3] <= ~level[p % 3];
            repeat (40) @(posedge pclk);
        end
        glitch <= 3'h1;
        @(posedge pclk);
        glitch <= 3'h0;
        apb(1'b1, PHASE_CTRL_OFF, 32'h51);
        level <= 3'h2;
        apb(1'b1, PHASE_CFG0_OFF, 32'h102);
        level <= 3'h3;
        repeat (40) @(posedge pclk);
        check(33'(zc_q.size()), 33'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        check(33'({reg_en, nsrc, pen, trim}), 33'(TRIM_DEFAULT));
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        report_and_stop();
    end
endmodule

// [testbench/bpd_motor_model.sv]
// Purpose: Winding and regulator model on the far side of bpd_ctrl.
// Assumes: Windings arrive divided down to comparator range.
// Notes:   Good follows regulator enable after SETTLE cycles.
`timescale 1ns/1ps
module bpd_motor_model #(
    parameter int SETTLE = 50
) (
    input  wire logic       pclk,
    input  wire logic [2:0] level,
    input  wire logic [2:0] glitch,
    input  wire logic       reg_en,
    output logic      [2:0] cmp_out,
    output logic            good
);
    int cnt = 0;

    // Compares each back-EMF with the neutral; glitch adds a noise spike.
    always @(posedge pclk) begin
        cmp_out <= level ^ glitch;
        cnt     <= reg_en ? (cnt < SETTLE ? cnt + 1 : cnt) : 0;
        good    <= reg_en && cnt >= SETTLE;
    end
endmodule
